// ### common/dma_buffer_pkg.sv
// Shared constants and request carrier for the dual-port DMA buffer RAM
package dma_buffer_pkg;

  // Region size in bytes, and in 16-bit words
  localparam int unsigned REGION_BYTES = 2048;
  localparam int unsigned REGION_WORDS = REGION_BYTES / 2;
  // Word index width inside the region
  localparam int unsigned WORD_ADDR_W  = $clog2(REGION_WORDS);
  // Data path and effective address widths
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned LANES        = DATA_W / 8;
  localparam int unsigned EA_W         = 16;
  // Region starts at the top end of Y data space (last 2 Kbytes below EA bit 15)
  localparam logic [15:0] REGION_BASE  = 16'h7800;
  // Bit position of the lowest region-select bit in an effective address
  localparam int unsigned SEL_LSB      = $clog2(REGION_BYTES);
  // Value returned for reads outside the region and after reset
  localparam logic [15:0] READ_RESET   = 16'h0000;

  // One access request, as issued by either port
  typedef struct packed {
    logic        en;     // Access this cycle
    logic        we;     // 1 write, 0 read
    logic [1:0]  be;     // Byte lane strobes, bit 0 low byte
    logic [15:0] ea;     // Byte effective address
    logic [15:0] wdata;  // Write data
  } port_req_type;

endpackage

// ### core/dma_buffer_mem.sv
// Two-port byte-lane memory array with registered read data
`timescale 1ns/100ps
module dma_buffer_mem #(
  parameter int unsigned WORDS  = 1024,
  parameter int unsigned ADDR_W = 10,
  parameter int unsigned LANES  = 2
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // Port A (core side)
  input  wire logic [LANES-1:0]      a_we_lane,
  input  wire logic                  a_rd,
  input  wire logic                  a_rd_hit,
  input  wire logic [ADDR_W-1:0]     a_addr,
  input  wire logic [LANES*8-1:0]    a_wdata,
  output logic      [LANES*8-1:0]    a_rdata,
  // Port B (DMA side)
  input  wire logic [LANES-1:0]      b_we_lane,
  input  wire logic                  b_rd,
  input  wire logic                  b_rd_hit,
  input  wire logic [ADDR_W-1:0]     b_addr,
  input  wire logic [LANES*8-1:0]    b_wdata,
  output logic      [LANES*8-1:0]    b_rdata
);

  // Storage array, no reset
  logic [LANES*8-1:0] mem [WORDS];

  // Writes: port B first, port A last, so A owns any lane both touch
  always_ff @(posedge clk)
  begin
    for (int l = 0; l < LANES; l++)
    begin
      if (b_we_lane[l])
        mem[b_addr][l*8 +: 8] <= b_wdata[l*8 +: 8];
      if (a_we_lane[l])
        mem[a_addr][l*8 +: 8] <= a_wdata[l*8 +: 8];
    end
  end

  // Registered reads; a miss outside the region returns zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      a_rdata <= '0;
      b_rdata <= '0;
    end
    else
    begin
      if (a_rd)
        a_rdata <= a_rd_hit ? mem[a_addr] : '0;
      if (b_rd)
        b_rdata <= b_rd_hit ? mem[b_addr] : '0;
    end
  end

endmodule

// ### core/dma_buffer_ram.sv
// Dual-ported DMA buffer RAM: core port and DMA port with core write precedence
//
// Function
// RQ1: 2-Kbyte region at top of Y space
// RQ2: Core and DMA ports reach any location together
// RQ3: DMA port holds data in both directions
// RQ4: DMA accesses never stall or delay core
// RQ5: Same-location concurrent writes: core value wins
// RQ6: Two byte lanes, shared decode, separate strobes
// RQ7: Colliding DMA write is discarded that cycle
`timescale 1ns/100ps
module dma_buffer_ram (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  // Processor core port
  input  wire dma_buffer_pkg::port_req_type core_req,
  output logic                              core_rvalid,
  output logic [15:0]                       core_rdata,
  // DMA controller port
  input  wire dma_buffer_pkg::port_req_type dma_req,
  output logic                              dma_rvalid,
  output logic [15:0]                       dma_rdata,
  // Status
  output logic                              dma_wr_dropped
);

  localparam int unsigned AW  = dma_buffer_pkg::WORD_ADDR_W;
  localparam int unsigned SEL = dma_buffer_pkg::SEL_LSB;

  // Region decode on the upper effective address bits
  wire logic          core_hit;       // Core address inside region
  wire logic          dma_hit;        // DMA address inside region
  wire logic [AW-1:0] core_word;      // Core word index
  wire logic [AW-1:0] dma_word;       // DMA word index
  wire logic          core_wr;        // Core write to region
  wire logic          dma_wr;         // DMA write to region
  wire logic          core_rd;        // Core read, any address
  wire logic          dma_rd;         // DMA read, any address
  wire logic          collide;        // Both write the same word
  wire logic [1:0]    core_we_lane;   // Core lane strobes
  wire logic [1:0]    dma_we_lane;    // DMA lane strobes after arbitration

  assign core_hit  = core_req.ea[15:SEL] == dma_buffer_pkg::REGION_BASE[15:SEL]; // RQ1
  assign dma_hit   = dma_req.ea[15:SEL]  == dma_buffer_pkg::REGION_BASE[15:SEL]; // RQ1
  assign core_word = core_req.ea[SEL-1:1];
  assign dma_word  = dma_req.ea[SEL-1:1];
  assign core_wr   = core_req.en & core_req.we & core_hit;
  assign dma_wr    = dma_req.en & dma_req.we & dma_hit; // RQ3
  assign core_rd   = core_req.en & ~core_req.we;
  assign dma_rd    = dma_req.en & ~dma_req.we;
  assign collide   = core_wr & dma_wr & (core_word == dma_word); // RQ5

  // Each lane has its own strobe; the word decode is shared
  assign core_we_lane = {2{core_wr}} & core_req.be; // RQ6
  assign dma_we_lane  = {2{dma_wr & ~collide}} & dma_req.be; // RQ7

  // Storage with two independent ports; the core port has no wait path at all
  dma_buffer_mem #(
    .WORDS  (dma_buffer_pkg::REGION_WORDS),
    .ADDR_W (AW),
    .LANES  (dma_buffer_pkg::LANES)
  ) u_mem (
    .clk       (clk),
    .reset_n   (reset_n),
    .a_we_lane (core_we_lane),
    .a_rd      (core_rd),
    .a_rd_hit  (core_hit),
    .a_addr    (core_word),
    .a_wdata   (core_req.wdata),
    .a_rdata   (core_rdata),
    .b_we_lane (dma_we_lane),
    .b_rd      (dma_rd),
    .b_rd_hit  (dma_hit),
    .b_addr    (dma_word),
    .b_wdata   (dma_req.wdata),
    .b_rdata   (dma_rdata)
  ); // RQ2

  // Read-valid and drop flags, one cycle after the request
  logic core_rvalid_r;    // Core read data valid
  logic dma_rvalid_r;     // DMA read data valid
  logic dma_wr_dropped_r; // DMA write lost to core

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // No read answer or drop pending out of reset
      core_rvalid_r    <= 1'b0;
      dma_rvalid_r     <= 1'b0;
      dma_wr_dropped_r <= 1'b0;
    end
    else
    begin
      // Each flag follows this cycle's requests, no wait state
      core_rvalid_r    <= core_rd; // RQ4
      dma_rvalid_r     <= dma_rd;
      dma_wr_dropped_r <= collide; // RQ7
    end
  end

  assign core_rvalid    = core_rvalid_r;
  assign dma_rvalid     = dma_rvalid_r;
  assign dma_wr_dropped = dma_wr_dropped_r;

  // Checks

  // Core read outside the region returns zero
  property p_core_miss_zero;
    @(posedge clk) disable iff (!reset_n)
    (core_rd && !core_hit) |=> (core_rvalid && core_rdata == dma_buffer_pkg::READ_RESET);
  endproperty
  a_core_miss_zero: assert property (p_core_miss_zero) else $error("core miss read not zero"); // RQ1

  // Both ports read in one cycle and both answer next cycle
  property p_dual_read;
    @(posedge clk) disable iff (!reset_n)
    (core_rd && dma_rd) |=> (core_rvalid && dma_rvalid);
  endproperty
  a_dual_read: assert property (p_dual_read) else $error("concurrent reads not both served"); // RQ2

  // DMA write then DMA read of same word returns the written data
  property p_dma_store;
    @(posedge clk) disable iff (!reset_n)
    (dma_wr && dma_req.be == 2'b11 && !core_wr) ##1 (dma_rd && dma_hit && dma_word == $past(dma_word)
      && !$past(core_wr))
    |=> (dma_rdata == $past(dma_req.wdata, 2));
  endproperty
  a_dma_store: assert property (p_dma_store) else $error("DMA store not read back"); // RQ3

  // Core reads are never delayed, whatever the DMA port does
  property p_core_no_stall;
    @(posedge clk) disable iff (!reset_n)
    core_rd |=> core_rvalid;
  endproperty
  a_core_no_stall: assert property (p_core_no_stall) else $error("core read delayed"); // RQ4

  // After a full-word collision the core value is stored
  property p_core_wins;
    @(posedge clk) disable iff (!reset_n)
    (collide && core_req.be == 2'b11) ##1 (core_rd && core_hit && core_word == $past(core_word))
    |=> (core_rdata == $past(core_req.wdata, 2));
  endproperty
  a_core_wins: assert property (p_core_wins) else $error("core write lost in collision"); // RQ5

  // A high-lane DMA write lands in the high byte
  property p_byte_lane;
    @(posedge clk) disable iff (!reset_n)
    (dma_wr && !collide && dma_req.be == 2'b10) ##1 (dma_rd && dma_hit && dma_word == $past(dma_word)
      && !$past(core_wr))
    |=> (dma_rdata[15:8] == $past(dma_req.wdata[15:8], 2));
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("byte lane write wrong"); // RQ6

  // A collision flags the dropped DMA write on the next cycle; the flag then follows collide
  property p_dma_drop;
    @(posedge clk) disable iff (!reset_n)
    collide |=> dma_wr_dropped ##1 (dma_wr_dropped == $past(collide));
  endproperty
  a_dma_drop: assert property (p_dma_drop) else $error("DMA drop flag wrong"); // RQ7

  // DMA read outside the region returns zero
  property p_dma_miss_zero;
    @(posedge clk) disable iff (!reset_n)
    (dma_rd && !dma_hit) |=> (dma_rvalid && dma_rdata == dma_buffer_pkg::READ_RESET);
  endproperty
  a_dma_miss_zero: assert property (p_dma_miss_zero) else $error("DMA miss read not zero"); // RQ1

  // Core write outside the region raises no lane strobe
  property p_core_miss_write;
    @(posedge clk) disable iff (!reset_n)
    (core_req.en && core_req.we && !core_hit) |-> (core_we_lane == 2'b00);
  endproperty
  a_core_miss_write: assert property (p_core_miss_write) else $error("core miss write reached array"); // RQ1

  // DMA write outside the region raises no lane strobe
  property p_dma_miss_write;
    @(posedge clk) disable iff (!reset_n)
    (dma_req.en && dma_req.we && !dma_hit) |-> (dma_we_lane == 2'b00);
  endproperty
  a_dma_miss_write: assert property (p_dma_miss_write) else $error("DMA miss write reached array"); // RQ1

  // Every DMA read is answered on the next cycle
  property p_dma_read_served;
    @(posedge clk) disable iff (!reset_n)
    dma_rd |=> dma_rvalid;
  endproperty
  a_dma_read_served: assert property (p_dma_read_served) else $error("DMA read not answered"); // RQ2

  // Core read-valid never pulses without a core read
  property p_core_rvalid_pulse;
    @(posedge clk) disable iff (!reset_n)
    !core_rd |=> !core_rvalid;
  endproperty
  a_core_rvalid_pulse: assert property (p_core_rvalid_pulse) else $error("core read valid without read"); // RQ4

  // DMA read-valid never pulses without a DMA read
  property p_dma_rvalid_pulse;
    @(posedge clk) disable iff (!reset_n)
    !dma_rd |=> !dma_rvalid;
  endproperty
  a_dma_rvalid_pulse: assert property (p_dma_rvalid_pulse) else $error("DMA read valid without read"); // RQ3

  // A low-lane core write lands in the low byte
  property p_core_low_lane;
    @(posedge clk) disable iff (!reset_n)
    (core_wr && core_req.be == 2'b01) ##1 (core_rd && core_hit && core_word == $past(core_word))
    |=> (core_rdata[7:0] == $past(core_req.wdata[7:0], 2));
  endproperty
  a_core_low_lane: assert property (p_core_low_lane) else $error("core low lane write wrong"); // RQ6

  // A collision removes every DMA lane strobe
  property p_collide_blocks_dma;
    @(posedge clk) disable iff (!reset_n)
    collide |-> (dma_we_lane == 2'b00);
  endproperty
  a_collide_blocks_dma: assert property (p_collide_blocks_dma) else $error("colliding DMA write reached array"); // RQ7

  // No drop flag without a collision
  property p_no_false_drop;
    @(posedge clk) disable iff (!reset_n)
    !collide |=> !dma_wr_dropped;
  endproperty
  a_no_false_drop: assert property (p_no_false_drop) else $error("DMA drop flag without collision"); // RQ7

endmodule

// ### tb/dma_port_partner.sv
// Random request source standing in for the processor core and the DMA controller
`timescale 1ns/100ps
module dma_port_partner (
  // Clock
  input  wire logic                    clk,
  // Requests toward the buffer
  output dma_buffer_pkg::port_req_type core_req,
  output dma_buffer_pkg::port_req_type dma_req
);
  // Fixed seed keeps every run identical
  integer seed = 32'hb5693ec9;

  // One request over a 16-word span; about one in sixteen falls outside the region
  function automatic dma_buffer_pkg::port_req_type draw(input logic [31:0] r);
    dma_buffer_pkg::port_req_type q;
    q.en    = r[0] | r[1];
    q.we    = r[2];
    // Never an empty strobe, so a collision is always a real one
    q.be    = (r[4:3] == 2'h0) ? 2'h3 : r[4:3];
    q.ea    = (r[8:5] == 4'h0) ? 16'h1000 : {5'h0f, 6'h00, r[12:9], r[13]};
    q.wdata = r[29:14];
    return q;
  endfunction

  // New pair of requests after every rising edge
  always @(posedge clk)
  begin
    core_req <= draw($random(seed));
    dma_req  <= draw($random(seed));
  end
endmodule

// ### tb/tb_dma_buffer_ram.sv
// Self-checking bench for the dual-port DMA buffer RAM
`timescale 1ns/100ps
module tb_dma_buffer_ram;
  logic                         clk      = 1'b0;  // 40 MHz clock
  logic                         reset_n  = 1'b0;  // Async reset
  logic                         active   = 1'b0;  // Random phase select
  dma_buffer_pkg::port_req_type tb_core  = '0;    // Directed core request
  dma_buffer_pkg::port_req_type tb_dma   = '0;    // Directed DMA request
  dma_buffer_pkg::port_req_type p_core, p_dma, core_req, dma_req;
  logic                         core_rvalid, dma_rvalid, dma_wr_dropped;
  logic [15:0]                  core_rdata, dma_rdata;
  logic                         e_crv = 1'b0, e_drv = 1'b0, e_drop = 1'b0;  // Expected pulses
  logic [15:0]                  e_crd = 16'h0000, e_drd = 16'h0000;          // Expected read data
  logic [15:0]                  shadow [0:1023];                             // Reference contents
  int                           failures = 0;
  int                           total_checks = 0;
  logic [3:0]                   cw, dw;                                      // Directed word indices

  always #12.5 clk = ~clk;
  // Source select between directed and random stimulus
  assign core_req = active ? p_core : tb_core;
  assign dma_req  = active ? p_dma : tb_dma;

  dma_port_partner partner_u (.clk(clk), .core_req(p_core), .dma_req(p_dma));
  dma_buffer_ram dut_u (.clk(clk), .reset_n(reset_n), .core_req(core_req), .core_rvalid(core_rvalid),
    .core_rdata(core_rdata), .dma_req(dma_req), .dma_rvalid(dma_rvalid), .dma_rdata(dma_rdata),
    .dma_wr_dropped(dma_wr_dropped));

  // Compare one value and report a mismatch
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Address lies inside the buffer region
  function automatic logic hit(input dma_buffer_pkg::port_req_type q);
    return q.ea[15:11] == 5'h0f;
  endfunction

  // Expected read value: region word or zero outside
  function automatic logic [15:0] rd(input dma_buffer_pkg::port_req_type q);
    return hit(q) ? shadow[q.ea[10:1]] : 16'h0000;
  endfunction

  // Apply a write lane by lane to the reference; writes outside are ignored
  task wr(input dma_buffer_pkg::port_req_type q);
    if (hit(q) && q.be[0]) shadow[q.ea[10:1]][7:0] = q.wdata[7:0];
    if (hit(q) && q.be[1]) shadow[q.ea[10:1]][15:8] = q.wdata[15:8];
  endtask

  // Check last edge's outputs, then predict the next edge from the settled requests
  always @(negedge clk)
  begin
    if (reset_n)
    begin
      check("core_rvalid", {15'h0, core_rvalid}, {15'h0, e_crv});
      check("dma_rvalid", {15'h0, dma_rvalid}, {15'h0, e_drv});
      check("core_rdata", core_rdata, e_crd);
      check("dma_rdata", dma_rdata, e_drd);
      check("dma_wr_dropped", {15'h0, dma_wr_dropped}, {15'h0, e_drop});
      e_crv = core_req.en & ~core_req.we;
      e_drv = dma_req.en & ~dma_req.we;
      // Reads see contents from before this edge's writes
      if (e_crv) e_crd = rd(core_req);
      if (e_drv) e_drd = rd(dma_req);
      e_drop = dma_req.en & dma_req.we & core_req.en & core_req.we & hit(core_req) & hit(dma_req)
        & (core_req.ea[10:1] == dma_req.ea[10:1]);
      if (dma_req.en & dma_req.we & !e_drop) wr(dma_req);
      if (core_req.en & core_req.we) wr(core_req);
    end
  end

  // Print counts and verdict, then stop
  task tally_and_finish;
    $display("Checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog well past the expected run length
  initial
  begin
    #(25 * 4000);
    failures++;
    tally_and_finish;
  end

  // Directed fill, byte-lane and full-word collisions each read back, then random traffic
  initial
  begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clk);
      cw = 4'((i < 8) ? i : 5 + (i - 8) / 2);
      dw = 4'((i < 8) ? i + 8 : 5 + (i - 8) / 2);
      tb_core <= '{1'b1, (i < 9) || (i == 10), (i == 8) ? 2'h1 : 2'h3, {11'h3c0, cw, 1'b0}, {8'(i), 8'(~i)}};
      tb_dma  <= '{1'b1, (i < 9) || (i == 10), (i == 8) ? 2'h2 : 2'h3, {11'h3c0, dw, 1'b0}, 16'ha5c3};
    end
    @(posedge clk);
    tb_core <= '0;
    tb_dma  <= '0;
    repeat (3) @(posedge clk);
    $display("Test directed done");
    active <= 1'b1;
    repeat (3000) @(posedge clk);
    $display("Test random done");
    tally_and_finish;
  end
endmodule
